// ==== rtl/pcr_pkg.sv ====
// Constants, types and register map of the clock and reset sequencer
package pcr_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          MULT_W           = 4;
    localparam int          BOOT_PINS        = 4;
    localparam logic [7:0]  OFF_PLL_MULT     = 8'h00;
    localparam logic [7:0]  OFF_EXT_CFG2     = 8'h04;
    localparam logic [7:0]  OFF_STATUS       = 8'h08;
    localparam logic [7:0]  OFF_WDOG         = 8'h0c;
    localparam logic [3:0]  PLL_MULT_RST     = 4'h0;
    localparam logic [2:0]  EXT_CFG2_RST     = 3'h7;
    localparam int          CFG_TIM_BIT      = 0;
    localparam int          CFG_OUTDIV_BIT   = 1;
    localparam int          CFG_OUTEN_BIT    = 2;
    localparam int          WD_KICK_BIT      = 0;
    localparam int          LOCK_CYCLES      = 131072;
    localparam int          LOCK_CYCLES_OLD  = 4096;
    localparam int          WD_PULSE_CYCLES  = 512;
    localparam int          BUS_VALID_CYCLES = 32;
    localparam int          BOOT_SYS_CYCLES  = 1260;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef enum logic [1:0] {
        CLK_DISABLED = 2'h0,
        CLK_BYPASS   = 2'h1,
        CLK_ENABLED  = 2'h2
    } pcr_clk_mode_t;

    typedef enum logic [3:0] {
        BOOT_RESET = 4'b0001,
        BOOT_RUN   = 4'b0010,
        BOOT_PWD   = 4'b0100,
        BOOT_DONE  = 4'b1000
    } pcr_boot_state_t;

    typedef struct packed {
        logic [BOOT_PINS-1:0] boot_mode;
        logic                 mp_mode;
        logic                 boot_done;
        logic                 bus_valid;
        logic                 wd_active;
        logic                 locking;
        pcr_clk_mode_t        clk_mode;
    } pcr_status_t;
endpackage

// ==== rtl/pcr_seq.sv ====
// Clock mode selection, clock output divider, reset and boot sequencing
// How it works
// R1 - Strap low at reset: reference clock undivided
// R2 - Not disabled: power-up bypass, reference over two
// R3 - Non-zero multiplier n gives reference times n/2
// R4 - Allow lock time after enable or ratio change
// R5 - Top system rate reachable only through PLL
// R6 - Clock output pin follows divided system clock; here edges round to reference cycles, so none in undivided disabled mode
// R7 - Both divide bits reset to one: divide four
// R8 - Reference stable eight cycles before reset release
// R9 - Warm reset pin held low eight cycles
// R10 - Watchdog reset drives pin low 512 cycles
// R11 - External bus valid 32 cycles after release
// R12 - Straps held sixteen cycles around reset release
// R13 - Boot runs 1260 system cycles, samples mode
// R14 - Boot pins held 2520 cycles from boot
// R15 - Password read happens before boot mode sampling
// R16 - Boot timing counts the system clock in effect
// R17 - Writing zero multiplier returns to bypass
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
module pcr_seq #(
    parameter int LOCK_CYCLES = pcr_pkg::LOCK_CYCLES
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [pcr_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [pcr_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          reset_pin_n_in,
    output logic                               reset_pin_n_out,
    output logic                               reset_pin_n_oe,
    input  wire logic                          pll_disable_strap_n,
    input  wire logic                          microprocessor_mode_strap,
    input  wire logic [pcr_pkg::BOOT_PINS-1:0] boot_mode_pins,
    output logic                               device_reset_n,
    output pcr_pkg::pcr_clk_mode_t             clock_mode,
    output logic [3:0]                         system_clock_ticks,
    output logic                               clock_output_pin,
    output logic                               ext_bus_valid,
    output logic                               pwd_read_stb,
    output logic                               boot_done,
    output logic [pcr_pkg::BOOT_PINS-1:0]      boot_mode_sel
);
    localparam int LW = $clog2(LOCK_CYCLES + 1);
    localparam int SW = pcr_pkg::BOOT_PINS + 3;

    logic [SW-1:0]                  sync1_q;
    logic [SW-1:0]                  sync2_q;
    logic                           strap_dis_n_q;
    logic                           mp_mode_q;
    logic [3:0]                     mult_q;
    logic [2:0]                     cfg_q;
    logic [LW-1:0]                  lock_cnt_q;
    logic [9:0]                     wd_cnt_q;
    logic                           half_acc_q;
    logic [3:0]                     phase_q;
    logic                           clk_out_q;
    logic [5:0]                     bus_cnt_q;
    logic [10:0]                    boot_cnt_q;
    logic [pcr_pkg::BOOT_PINS-1:0]  boot_mode_q;
    pcr_pkg::pcr_boot_state_t       state_q;
    pcr_pkg::pcr_boot_state_t       state_d;
    logic                           aw_full_q;
    logic                           w_full_q;
    logic [pcr_pkg::ADDR_W-1:0]     aw_addr_q;
    logic [31:0]                    w_data_q;
    logic                           w_lane0_q;
    logic                           bvalid_q;
    logic [1:0]                     bresp_q;
    logic                           rvalid_q;
    logic [31:0]                    rdata_q;
    logic [1:0]                     rresp_q;

    // Synchronisers: only sync2_q feeds logic
    wire  [SW-1:0] pins_raw = {boot_mode_pins, microprocessor_mode_strap,
                               pll_disable_strap_n, reset_pin_n_in};
    wire           pin_rst_n = sync2_q[0];
    wire           wd_active = (wd_cnt_q != 10'h000);
    wire           dev_rst   = !pin_rst_n || wd_active;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    // Straps track the pins while in reset and freeze at release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_dis_n_q <= 1'b1;
            mp_mode_q     <= 1'b0;
        end else if (dev_rst) begin
            strap_dis_n_q <= sync2_q[1]; // R1 R12
            mp_mode_q     <= sync2_q[2]; // R12
        end
    end

    // Bus slave decode
    wire wr_go    = aw_full_q && w_full_q && !bvalid_q;
    wire wr_mult  = wr_go && w_lane0_q && (aw_addr_q == pcr_pkg::OFF_PLL_MULT);
    wire wr_cfg   = wr_go && w_lane0_q && (aw_addr_q == pcr_pkg::OFF_EXT_CFG2);
    wire wr_wdog  = wr_go && (aw_addr_q == pcr_pkg::OFF_WDOG);
    wire wr_known = (aw_addr_q == pcr_pkg::OFF_PLL_MULT) || (aw_addr_q == pcr_pkg::OFF_EXT_CFG2)
                    || (aw_addr_q == pcr_pkg::OFF_STATUS) || wr_wdog;
    wire wd_fire  = wr_wdog && w_lane0_q && w_data_q[pcr_pkg::WD_KICK_BIT] && !wd_active;
    wire [3:0] new_mult = w_data_q[pcr_pkg::MULT_W-1:0];
    wire lock_start = wr_mult && (new_mult != 4'h0) && (new_mult != mult_q);
    wire ar_go    = s_axi_arvalid && !rvalid_q;
    wire rd_known = (s_axi_araddr == pcr_pkg::OFF_PLL_MULT)
                    || (s_axi_araddr == pcr_pkg::OFF_EXT_CFG2)
                    || (s_axi_araddr == pcr_pkg::OFF_STATUS)
                    || (s_axi_araddr == pcr_pkg::OFF_WDOG);

    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready  = !w_full_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_lane0_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= pcr_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q  <= 1'b1;
                w_data_q  <= s_axi_wdata;
                w_lane0_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_known ? pcr_pkg::RESP_OKAY : pcr_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
            end
        end
    end

    pcr_pkg::pcr_status_t status;
    assign status = '{boot_mode: boot_mode_q, mp_mode: mp_mode_q, boot_done: boot_done,
                      bus_valid: ext_bus_valid, wd_active: wd_active,
                      locking: (lock_cnt_q != '0), clk_mode: clock_mode};
    wire [31:0] rd_mux =
        (s_axi_araddr == pcr_pkg::OFF_PLL_MULT) ? {28'h0, mult_q} :
        (s_axi_araddr == pcr_pkg::OFF_EXT_CFG2) ? {29'h0, cfg_q} :
        (s_axi_araddr == pcr_pkg::OFF_STATUS)   ? {{(32 - $bits(status)){1'b0}}, status} :
        32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= pcr_pkg::RESP_OKAY;
        end else if (ar_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_known ? pcr_pkg::RESP_OKAY : pcr_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Control registers return to reset values on any device reset
    always_ff @(posedge aclk) begin
        if (!aresetn || dev_rst) begin
            mult_q     <= pcr_pkg::PLL_MULT_RST;
            cfg_q      <= pcr_pkg::EXT_CFG2_RST; // R7
            lock_cnt_q <= '0;
        end else begin
            if (wr_mult) begin
                mult_q <= new_mult; // R3 R17
            end
            if (wr_cfg) begin
                cfg_q <= w_data_q[2:0];
            end
            if (lock_start) begin
                lock_cnt_q <= LW'(LOCK_CYCLES); // R4
            end else if (lock_cnt_q != '0) begin
                lock_cnt_q <= lock_cnt_q - LW'(1);
            end
        end
    end

    // Watchdog counter survives the reset it causes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_cnt_q <= '0;
        end else if (wd_fire) begin
            wd_cnt_q <= 10'(pcr_pkg::WD_PULSE_CYCLES); // R10
        end else if (wd_active) begin
            wd_cnt_q <= wd_cnt_q - 10'h001;
        end
    end
    assign reset_pin_n_out = 1'b0;
    assign reset_pin_n_oe  = wd_active; // R10
    assign device_reset_n  = !dev_rst;

    // Clock runs in bypass while the PLL settles
    assign clock_mode = !strap_dis_n_q ? pcr_pkg::CLK_DISABLED :            // R1
                        (mult_q != 4'h0 && lock_cnt_q == '0) ? pcr_pkg::CLK_ENABLED : // R3 R4
                        pcr_pkg::CLK_BYPASS;                                 // R2 R17

    // System clock rate in half cycles per reference cycle
    wire [3:0] inc_half = (clock_mode == pcr_pkg::CLK_DISABLED) ? 4'h2 :
                          (clock_mode == pcr_pkg::CLK_ENABLED)  ? mult_q : 4'h1; // R5
    wire [4:0] half_sum = {4'h0, half_acc_q} + {1'b0, inc_half};
    wire [1:0] div_sh   = {1'b0, cfg_q[pcr_pkg::CFG_TIM_BIT]}
                          + {1'b0, cfg_q[pcr_pkg::CFG_OUTDIV_BIT]};
    wire [3:0] ph_mask  = (div_sh == 2'h0) ? 4'h1 : (div_sh == 2'h1) ? 4'h3 : 4'h7;
    wire [3:0] phase_d  = (phase_q + inc_half) & ph_mask;
    assign system_clock_ticks = half_sum[4:1];

    // Pin edges round to reference cycles, so undivided disabled mode cannot toggle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_acc_q <= 1'b0;
            phase_q    <= '0;
            clk_out_q  <= 1'b0;
        end else begin
            half_acc_q <= half_sum[0];
            phase_q    <= phase_d;
            clk_out_q  <= cfg_q[pcr_pkg::CFG_OUTEN_BIT] && !phase_d[div_sh]; // R6 R7
        end
    end
    assign clock_output_pin = clk_out_q;

    // Reset release to bus valid
    always_ff @(posedge aclk) begin
        if (!aresetn || dev_rst) begin
            bus_cnt_q <= '0;
        end else if (bus_cnt_q != 6'(pcr_pkg::BUS_VALID_CYCLES)) begin
            bus_cnt_q <= bus_cnt_q + 6'h01; // R11
        end
    end
    assign ext_bus_valid = (bus_cnt_q == 6'(pcr_pkg::BUS_VALID_CYCLES));

    // Boot sequence counts system cycles, so its length follows the clock mode
    wire [10:0] boot_next = boot_cnt_q + {7'h00, system_clock_ticks}; // R16
    wire        boot_end  = boot_next >= 11'(pcr_pkg::BOOT_SYS_CYCLES);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pcr_pkg::BOOT_RESET: state_d = pcr_pkg::BOOT_RUN;
            pcr_pkg::BOOT_RUN:   state_d = boot_end ? pcr_pkg::BOOT_PWD : state_q; // R13
            pcr_pkg::BOOT_PWD:   state_d = pcr_pkg::BOOT_DONE; // R15
            pcr_pkg::BOOT_DONE:  state_d = state_q;
            default:             state_d = pcr_pkg::BOOT_RESET;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || dev_rst) begin
            state_q     <= pcr_pkg::BOOT_RESET;
            boot_cnt_q  <= '0;
            boot_mode_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == pcr_pkg::BOOT_RUN) begin
                boot_cnt_q <= boot_next; // R13
            end
            if (state_q == pcr_pkg::BOOT_PWD) begin
                boot_mode_q <= sync2_q[SW-1:3]; // R13 R15
            end
        end
    end
    assign pwd_read_stb  = (state_q == pcr_pkg::BOOT_PWD);
    assign boot_done     = (state_q == pcr_pkg::BOOT_DONE);
    assign boot_mode_sel = boot_mode_q;

    a_disabled_rate: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        !strap_dis_n_q |-> system_clock_ticks == 4'h1)
        else $error("disabled mode not at reference rate");
    a_bypass_rate: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        clock_mode == pcr_pkg::CLK_BYPASS && $past(clock_mode) == pcr_pkg::CLK_BYPASS
        && $past(aresetn) |-> system_clock_ticks + $past(system_clock_ticks) == 4'h1)
        else $error("bypass not half reference rate");
    a_enabled_rate: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        clock_mode == pcr_pkg::CLK_ENABLED && $past(clock_mode) == pcr_pkg::CLK_ENABLED
        && $past(mult_q) == mult_q |-> system_clock_ticks + $past(system_clock_ticks) == mult_q)
        else $error("enabled rate not n over two");
    a_lock_wait: assert property (@(posedge aclk) disable iff (!aresetn || dev_rst) // R4
        lock_start |=> (clock_mode != pcr_pkg::CLK_ENABLED)[*8])
        else $error("PLL used before lock time");
    a_fast_pll_only: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        system_clock_ticks > 4'h1 |-> clock_mode == pcr_pkg::CLK_ENABLED)
        else $error("fast clock without PLL");
    a_cfg_reset: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        dev_rst |=> cfg_q == pcr_pkg::EXT_CFG2_RST)
        else $error("divide bits not one after reset");
    a_wd_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        wd_fire |=> reset_pin_n_oe && wd_cnt_q == 10'(pcr_pkg::WD_PULSE_CYCLES))
        else $error("watchdog pulse length wrong");
    a_bus_valid_time: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        $rose(ext_bus_valid) |-> $past(dev_rst, 33) && !$past(dev_rst, 32))
        else $error("bus valid not 32 cycles after release");
    a_boot_length: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        $rose(pwd_read_stb) |-> boot_cnt_q >= 11'(pcr_pkg::BOOT_SYS_CYCLES))
        else $error("boot sampled too early");
    a_pwd_first: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        $rose(boot_done) |-> $past(pwd_read_stb))
        else $error("boot mode sampled before password read");
    a_zero_bypass: assert property (@(posedge aclk) disable iff (!aresetn) // R17
        wr_mult && new_mult == 4'h0 && strap_dis_n_q && !dev_rst
        |=> clock_mode == pcr_pkg::CLK_BYPASS)
        else $error("zero multiplier not bypass");
    c_pll_locked: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(clock_mode == pcr_pkg::CLK_ENABLED));
    c_watchdog: cover property (@(posedge aclk) disable iff (!aresetn) $fell(wd_active));
    c_boot_done: cover property (@(posedge aclk) disable iff (!aresetn) $rose(boot_done));
endmodule

// ==== bench/pcr_supervisor.sv ====
// Reset supervisor model that drives the reset pin, the straps and the boot pins
module pcr_supervisor (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       go,
    input  wire logic       strap_val,
    input  wire logic       mp_val,
    input  wire logic [3:0] boot_val,
    output logic            pin_drive_n,
    output logic            pll_disable_strap_n,
    output logic            microprocessor_mode_strap,
    output logic [3:0]      boot_mode_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] hold_q;
    // Twenty cycles low covers both the low-time minimum and the strap setup
    assign pin_drive_n = (hold_q == 5'h00);
    always_ff @(posedge aclk) begin
        if (!aresetn || go) begin
            hold_q                    <= 5'h14;
            pll_disable_strap_n       <= strap_val;
            microprocessor_mode_strap <= mp_val;
            boot_mode_pins            <= boot_val;
        end else if (hold_q != 5'h00) begin
            hold_q <= hold_q - 5'h01;
        end
    end
    // Straps and boot pins only move together with a new reset, so holds are kept
endmodule

// ==== bench/pcr_seq_tb.sv ====
// Self-checking testbench of the clock and reset sequencer
module pcr_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOCK = 16;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, system_clock_ticks, boot_mode_pins, boot_mode_sel, boot_val, mult;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe, pll_disable_strap_n, sup_pin_n;
    logic microprocessor_mode_strap, device_reset_n, clock_output_pin, ext_bus_valid;
    logic pwd_read_stb, boot_done, sup_go, strap_val, mp_val, pwd_seen, prev_clk;
    pcr_pkg::pcr_clk_mode_t clock_mode;
    logic [33:0] acc_ticks, acc_edges, acc_oe, c;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    int error_cnt, samples_checked, seed;

    pcr_seq #(.LOCK_CYCLES(LOCK)) i_pcr_seq (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin_n_in,
        .reset_pin_n_out, .reset_pin_n_oe, .pll_disable_strap_n, .microprocessor_mode_strap,
        .boot_mode_pins, .device_reset_n, .clock_mode, .system_clock_ticks, .clock_output_pin,
        .ext_bus_valid, .pwd_read_stb, .boot_done, .boot_mode_sel);
    pcr_supervisor i_pcr_supervisor (.aclk, .aresetn, .go(sup_go), .strap_val, .mp_val,
        .boot_val, .pin_drive_n(sup_pin_n), .pll_disable_strap_n, .microprocessor_mode_strap,
        .boot_mode_pins);
    // Open-drain pin with pull-up: low if either party pulls it down
    assign reset_pin_n_in = sup_pin_n & ~(reset_pin_n_oe & ~reset_pin_n_out);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic results;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Results are compared at the falling edge, clear of the launching edge
    always @(negedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
        if (pwd_read_stb && !boot_done) pwd_seen = 1'b1;
        acc_ticks += {30'h0, system_clock_ticks};
        acc_edges += {33'h0, clock_output_pin && !prev_clk};
        acc_oe += {33'h0, reset_pin_n_oe};
        prev_clk = clock_output_pin;
    end

    task automatic span(input int n);
        @(posedge aclk);
        acc_ticks = 0;
        acc_edges = 0;
        repeat (n) @(negedge aclk);
        @(posedge aclk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        logic ta, tw, da, dw, tb;
        int n;
        exp_b.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        da = 0;
        dw = 0;
        n = 0;
        while (!(da && dw) && n < 50) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            n++;
            @(posedge aclk);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                da = 1;
            end
            if (tw) begin
                s_axi_wvalid <= 1'b0;
                dw = 1;
            end
        end
        s_axi_bready <= 1'b1;
        tb = 0;
        while (!tb && n < 100) begin
            @(negedge aclk);
            tb = s_axi_bvalid;
            n++;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
        if (!tb) error_cnt++;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        logic t;
        int n;
        exp_r.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        t = 0;
        n = 0;
        while (!t && n < 50) begin
            @(negedge aclk);
            t = s_axi_arready;
            n++;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        t = 0;
        while (!t && n < 100) begin
            @(negedge aclk);
            t = s_axi_rvalid;
            n++;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
        if (!t) error_cnt++;
    endtask

    // Follows one device reset from entry to the end of the boot run
    task automatic seq_check(input int lo, input int hi);
        int n;
        n = 0;
        pwd_seen = 1'b0;
        while (device_reset_n === 1'b1 && n < 50) begin @(negedge aclk); n++; end
        while (device_reset_n !== 1'b1 && n < 1000) begin @(negedge aclk); n++; end
        c = 0;
        while (ext_bus_valid !== 1'b1 && c < 100) begin @(negedge aclk); c++; end
        chk(c, 34'd32);
        while (boot_done !== 1'b1 && c < 3000) begin @(negedge aclk); c++; end
        chk({33'h0, c >= lo && c <= hi}, 34'h1);
        chk({30'h0, boot_mode_sel}, {30'h0, boot_val});
        chk({33'h0, pwd_seen}, 34'h1);
    endtask

    initial begin
        #200000;
        error_cnt++;
        results;
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
        seed = 58;
        sup_go = 1'b0;
        strap_val = 1'b1;
        mp_val = 1'($random(seed));
        boot_val = 4'($random(seed));
        {acc_ticks, acc_edges, acc_oe, prev_clk, pwd_seen} = '0;
        aresetn = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        seq_check(2500, 2545);
        axi_rd(pcr_pkg::OFF_EXT_CFG2, {31'h0, pcr_pkg::EXT_CFG2_RST});
        axi_rd(pcr_pkg::OFF_PLL_MULT, 34'h0);
        axi_rd(pcr_pkg::OFF_STATUS, {23'h0, boot_val, mp_val, 4'hc, 2'h1});
        axi_rd(pcr_pkg::OFF_WDOG, 34'h0);
        axi_rd(8'h10, {pcr_pkg::RESP_SLVERR, 32'h0});
        span(64);
        chk(acc_ticks, 34'd32);
        chk(acc_edges, 34'd8);
        axi_wr(pcr_pkg::OFF_EXT_CFG2, 8'h04, pcr_pkg::RESP_OKAY);
        span(64);
        chk(acc_edges, 34'd32);
        axi_wr(pcr_pkg::OFF_EXT_CFG2, 8'h05, pcr_pkg::RESP_OKAY);
        span(64);
        chk(acc_edges, 34'd16);
        axi_wr(pcr_pkg::OFF_EXT_CFG2, 8'h03, pcr_pkg::RESP_OKAY);
        span(64);
        chk(acc_edges, 34'd0);
        axi_wr(8'h14, 8'h01, pcr_pkg::RESP_SLVERR);
        axi_wr(pcr_pkg::OFF_EXT_CFG2, 8'h07, pcr_pkg::RESP_OKAY);
        mult = 4'($unsigned($random(seed)) % 15 + 1);
        axi_wr(pcr_pkg::OFF_PLL_MULT, {4'h0, mult}, pcr_pkg::RESP_OKAY);
        @(negedge aclk);
        chk({32'h0, clock_mode}, {32'h0, pcr_pkg::CLK_BYPASS});
        c = 0;
        while (clock_mode !== pcr_pkg::CLK_ENABLED && c < 100) begin @(negedge aclk); c++; end
        chk({33'h0, c >= 8 && c <= LOCK}, 34'h1);
        span(20);
        chk(acc_ticks, {30'h0, mult} * 34'd10);
        axi_wr(pcr_pkg::OFF_PLL_MULT, 8'h00, pcr_pkg::RESP_OKAY);
        span(20);
        chk(acc_ticks, 34'd10);
        acc_oe = 0;
        axi_wr(pcr_pkg::OFF_WDOG, 8'h01, pcr_pkg::RESP_OKAY);
        seq_check(2500, 2545);
        chk(acc_oe, 34'd512);
        @(posedge aclk);
        strap_val <= 1'b0;
        boot_val <= 4'($random(seed));
        sup_go <= 1'b1;
        @(posedge aclk);
        sup_go <= 1'b0;
        seq_check(1250, 1285);
        span(20);
        chk(acc_ticks, 34'd20);
        axi_wr(pcr_pkg::OFF_PLL_MULT, 8'h04, pcr_pkg::RESP_OKAY);
        span(40);
        @(negedge aclk);
        chk({32'h0, clock_mode}, {32'h0, pcr_pkg::CLK_DISABLED});
        results;
    end
endmodule
